// >>> pkg/asc_map.svh
// Notes on behaviour
// R1 - shift only while chip select low
// R2 - data captured on rising serial clock
// R3 - every 24th edge loads addressed register
// R4 - trailing partial word is dropped
// R5 - back-to-back words within one select
// R6 - first 8 bits address, then 16 data
// R7 - serial clock up to 20MHz, any duty; the host model clocks it with a 12ns period
// R8 - host resets registers after power-up
// R9 - low reset pin restores all defaults
// R10 - soft reset bit loads defaults, self-clears
// R11 - reset pin stays high during soft reset
// R12 - D8 of 0F selects partial sleep
// R13 - D9 selects complete sleep
// R14 - D10 routes sleep pin to partial/complete
// R15 - complete sleep wakes within 50us
// R16 - partial sleep wakes within 2us
// R17 - address 11 holds three drive fields
// R18 - address 12 termination enable and fields
// R19 - address 14 per-channel noise suppression
// R20 - address 24 per-channel input swap
// R21 - D6 alone selects ramp pattern
// R22 - D5 alone selects two-code pattern
// R23 - host writes undefined bits as zero
// R24 - host writes shared register at once
// R25 - D4 alone selects one-code pattern
// R26 - words shift most significant bit first
// R27 - write-only port, no readback
`ifndef ASC_MAP_SVH
`define ASC_MAP_SVH
// --------------------------------------------------
// register offsets
// --------------------------------------------------
`define ASC_ADDR_SOFT_RST 8'h00
`define ASC_ADDR_SLEEP 8'h0f
`define ASC_ADDR_DRIVE 8'h11
`define ASC_ADDR_TERM 8'h12
`define ASC_ADDR_NOISE 8'h14
`define ASC_ADDR_SWAP 8'h24
`define ASC_ADDR_PATTERN 8'h25
// --------------------------------------------------
// field positions
// --------------------------------------------------
`define ASC_SOFT_RST_BIT 0
`define ASC_PARTIAL_BIT 8
`define ASC_FULL_BIT 9
`define ASC_PINSEL_BIT 10
`define ASC_TERM_EN_BIT 14
`define ASC_BITCLK_LSB 0
`define ASC_FRAME_LSB 4
`define ASC_DATA_LSB 8
`define ASC_PAT_LSB 4
`define ASC_LAST_BIT 5'h17
// --------------------------------------------------
// reset values
// --------------------------------------------------
`define ASC_RST_FIELD 3'h0
`define ASC_RST_CH 8'h00
// --------------------------------------------------
// timing
// --------------------------------------------------
`define ASC_CLK_MHZ 40
`define ASC_WAKE_FULL_NS 50000
`define ASC_WAKE_PART_NS 2000
`define ASC_WAKE_FULL_CYC (`ASC_WAKE_FULL_NS * `ASC_CLK_MHZ / 1000)
`define ASC_WAKE_PART_CYC (`ASC_WAKE_PART_NS * `ASC_CLK_MHZ / 1000)
`endif

// >>> pkg/asc_pkg.sv
package asc_pkg;
  typedef enum logic [1:0] {
    ASC_PAT_NONE,
    ASC_PAT_RAMP,
    ASC_PAT_TWO,
    ASC_PAT_ONE
  } asc_pat_t;
  typedef enum logic [1:0] {
    ASC_PWR_ON,
    ASC_PWR_PART,
    ASC_PWR_FULL,
    ASC_PWR_WAKE
  } asc_pwr_t;
endpackage : asc_pkg

// >>> verilog/asc_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "asc_map.svh"
module asc_config_regs (
  // system
  input wire logic clk_sys,
  input wire logic sys_rst,
  // serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic serial_data_in,
  // pins
  input wire logic reset_pin_n,
  input wire logic sleep_pin,
  // sleep control
  output logic [7:0] channel_sleep_bits,
  output logic partial_sleep_bit,
  output logic full_sleep_bit,
  output logic sleep_pin_select_bit,
  output asc_pkg::asc_pwr_t power_state,
  output logic device_awake,
  // output buffers
  output logic [2:0] bitclk_drive_field,
  output logic [2:0] frameclk_drive_field,
  output logic [2:0] dataout_drive_field,
  output logic term_enable,
  output logic [2:0] bitclk_term_field,
  output logic [2:0] frameclk_term_field,
  output logic [2:0] dataout_term_field,
  // channel options
  output logic [7:0] noise_suppress_bits,
  output logic [7:0] input_swap_bits,
  output asc_pkg::asc_pat_t pattern_mode
);
  import asc_pkg::*;

  localparam logic [10:0] FULL_CYC = 11'(`ASC_WAKE_FULL_CYC);
  localparam logic [10:0] PART_CYC = 11'(`ASC_WAKE_PART_CYC);
  localparam int PART_MAX = `ASC_WAKE_PART_CYC + 2;

  // --------------------------------------------------
  // serial clock domain
  // --------------------------------------------------
  logic [4:0] bit_cnt_r;
  logic [22:0] shift_r;
  logic [23:0] word_r;
  logic word_tgl_r;

  // select high clears the count, so a partial word dies
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt_r <= 5'h00; // R1 R4
    end else if (bit_cnt_r == `ASC_LAST_BIT) begin
      bit_cnt_r <= 5'h00; // R5
    end else begin
      bit_cnt_r <= bit_cnt_r + 5'h01; // R2
    end
  end

  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      shift_r <= 23'h000000;
    end else begin
      shift_r <= {shift_r[21:0], serial_data_in}; // R2 R26
    end
  end

  // word holds for 24 serial edges, far longer than the sync path
  always_ff @(posedge sclk or posedge sys_rst) begin
    if (sys_rst) begin
      word_r <= 24'h000000;
      word_tgl_r <= 1'b0;
    end else if (!cs_n && bit_cnt_r == `ASC_LAST_BIT) begin
      word_r <= {shift_r, serial_data_in}; // R3 R7
      word_tgl_r <= ~word_tgl_r; // R3 R5
    end
  end

  // --------------------------------------------------
  // crossings into the system clock
  // --------------------------------------------------
  logic tgl_s1_r, tgl_s2_r, tgl_s3_r;
  logic rpin_s1_r, rpin_s2_r;
  logic spin_s1_r, spin_s2_r;
  logic wr_stb_r;
  logic [23:0] wr_word_r;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      tgl_s1_r <= 1'b0;
      tgl_s2_r <= 1'b0;
      tgl_s3_r <= 1'b0;
    end else begin
      tgl_s1_r <= word_tgl_r;
      tgl_s2_r <= tgl_s1_r;
      tgl_s3_r <= tgl_s2_r;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rpin_s1_r <= 1'b1;
      rpin_s2_r <= 1'b1;
      spin_s1_r <= 1'b0;
      spin_s2_r <= 1'b0;
    end else begin
      rpin_s1_r <= reset_pin_n;
      rpin_s2_r <= rpin_s1_r;
      spin_s1_r <= sleep_pin;
      spin_s2_r <= spin_s1_r;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wr_stb_r <= 1'b0;
      wr_word_r <= 24'h000000;
    end else begin
      wr_stb_r <= tgl_s2_r ^ tgl_s3_r;
      if (tgl_s2_r ^ tgl_s3_r) begin
        wr_word_r <= word_r;
      end
    end
  end

  // --------------------------------------------------
  // register file
  // --------------------------------------------------
  logic soft_rst_r;
  logic load_dflt;
  logic [15:0] wr_data;

  function automatic logic hit(input logic [23:0] w, input logic [7:0] a);
    hit = (w[23:16] == a); // R6
  endfunction : hit

  assign wr_data = wr_word_r[15:0]; // R6
  // pin reset wins over soft reset, which wins over writes
  assign load_dflt = !rpin_s2_r || soft_rst_r; // R9 R10

  // one-cycle self-clearing bit; nothing can read it back
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      soft_rst_r <= 1'b0;
    end else begin
      soft_rst_r <= rpin_s2_r && !soft_rst_r && wr_stb_r &&
                    hit(wr_word_r, `ASC_ADDR_SOFT_RST) &&
                    wr_data[`ASC_SOFT_RST_BIT]; // R10 R27
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      channel_sleep_bits <= `ASC_RST_CH;
      partial_sleep_bit <= 1'b0;
      full_sleep_bit <= 1'b0;
      sleep_pin_select_bit <= 1'b0;
    end else if (load_dflt) begin
      channel_sleep_bits <= `ASC_RST_CH;
      partial_sleep_bit <= 1'b0;
      full_sleep_bit <= 1'b0;
      sleep_pin_select_bit <= 1'b0; // R14
    end else if (wr_stb_r && hit(wr_word_r, `ASC_ADDR_SLEEP)) begin
      channel_sleep_bits <= wr_data[7:0];
      partial_sleep_bit <= wr_data[`ASC_PARTIAL_BIT]; // R12
      full_sleep_bit <= wr_data[`ASC_FULL_BIT]; // R13
      sleep_pin_select_bit <= wr_data[`ASC_PINSEL_BIT]; // R14
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      bitclk_drive_field <= `ASC_RST_FIELD;
      frameclk_drive_field <= `ASC_RST_FIELD;
      dataout_drive_field <= `ASC_RST_FIELD;
    end else if (load_dflt) begin
      bitclk_drive_field <= `ASC_RST_FIELD;
      frameclk_drive_field <= `ASC_RST_FIELD;
      dataout_drive_field <= `ASC_RST_FIELD;
    end else if (wr_stb_r && hit(wr_word_r, `ASC_ADDR_DRIVE)) begin
      bitclk_drive_field <= wr_data[`ASC_BITCLK_LSB +: 3]; // R17
      frameclk_drive_field <= wr_data[`ASC_FRAME_LSB +: 3];
      dataout_drive_field <= wr_data[`ASC_DATA_LSB +: 3];
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      term_enable <= 1'b0;
      bitclk_term_field <= `ASC_RST_FIELD;
      frameclk_term_field <= `ASC_RST_FIELD;
      dataout_term_field <= `ASC_RST_FIELD;
    end else if (load_dflt) begin
      term_enable <= 1'b0;
      bitclk_term_field <= `ASC_RST_FIELD;
      frameclk_term_field <= `ASC_RST_FIELD;
      dataout_term_field <= `ASC_RST_FIELD;
    end else if (wr_stb_r && hit(wr_word_r, `ASC_ADDR_TERM)) begin
      term_enable <= wr_data[`ASC_TERM_EN_BIT]; // R18
      bitclk_term_field <= wr_data[`ASC_BITCLK_LSB +: 3];
      frameclk_term_field <= wr_data[`ASC_FRAME_LSB +: 3];
      dataout_term_field <= wr_data[`ASC_DATA_LSB +: 3];
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      noise_suppress_bits <= `ASC_RST_CH;
    end else if (load_dflt) begin
      noise_suppress_bits <= `ASC_RST_CH;
    end else if (wr_stb_r && hit(wr_word_r, `ASC_ADDR_NOISE)) begin
      noise_suppress_bits <= wr_data[7:0]; // R19
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      input_swap_bits <= `ASC_RST_CH;
    end else if (load_dflt) begin
      input_swap_bits <= `ASC_RST_CH;
    end else if (wr_stb_r && hit(wr_word_r, `ASC_ADDR_SWAP)) begin
      input_swap_bits <= wr_data[7:0]; // R20
    end
  end

  // a mix of pattern bits is not a mode; outputs stay normal
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pattern_mode <= ASC_PAT_NONE;
    end else if (load_dflt) begin
      pattern_mode <= ASC_PAT_NONE;
    end else if (wr_stb_r && hit(wr_word_r, `ASC_ADDR_PATTERN)) begin
      case (wr_data[`ASC_PAT_LSB +: 3])
        3'h4: pattern_mode <= ASC_PAT_RAMP; // R21
        3'h2: pattern_mode <= ASC_PAT_TWO; // R22
        3'h1: pattern_mode <= ASC_PAT_ONE; // R25
        default: pattern_mode <= ASC_PAT_NONE;
      endcase
    end
  end

  // --------------------------------------------------
  // power state and wake timing
  // --------------------------------------------------
  logic full_req, part_req;
  asc_pwr_t pwr_nxt;
  logic [10:0] wake_cnt_r, wake_cnt_nxt;

  assign full_req = full_sleep_bit ||
                    (spin_s2_r && !sleep_pin_select_bit); // R13 R14
  assign part_req = partial_sleep_bit ||
                    (spin_s2_r && sleep_pin_select_bit); // R12 R14

  always_comb begin
    pwr_nxt = power_state;
    wake_cnt_nxt = wake_cnt_r;
    case (power_state)
      ASC_PWR_ON, ASC_PWR_WAKE: begin
        if (full_req) begin
          pwr_nxt = ASC_PWR_FULL;
        end else if (part_req) begin
          pwr_nxt = ASC_PWR_PART;
        end else if (power_state == ASC_PWR_WAKE) begin
          if (wake_cnt_r == 11'h000) begin
            pwr_nxt = ASC_PWR_ON;
          end else begin
            wake_cnt_nxt = wake_cnt_r - 11'h001;
          end
        end
      end
      ASC_PWR_FULL: begin
        if (!full_req) begin
          pwr_nxt = part_req ? ASC_PWR_PART : ASC_PWR_WAKE;
          wake_cnt_nxt = FULL_CYC - 11'h001; // R15
        end
      end
      ASC_PWR_PART: begin
        if (full_req) begin
          pwr_nxt = ASC_PWR_FULL;
        end else if (!part_req) begin
          pwr_nxt = ASC_PWR_WAKE;
          wake_cnt_nxt = PART_CYC - 11'h001; // R16
        end
      end
      default: pwr_nxt = ASC_PWR_ON;
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      power_state <= ASC_PWR_ON;
      wake_cnt_r <= 11'h000;
      device_awake <= 1'b1;
    end else begin
      power_state <= pwr_nxt;
      wake_cnt_r <= wake_cnt_nxt;
      device_awake <= (pwr_nxt == ASC_PWR_ON); // R15 R16
    end
  end

  // --------------------------------------------------
  // assertions
  // --------------------------------------------------
  a_word_on_last: assert property (@(posedge sclk) disable iff (cs_n || sys_rst) // R3
    bit_cnt_r == `ASC_LAST_BIT |=> word_tgl_r != $past(word_tgl_r))
    else $error("word not taken on 24th edge");

  a_partial_dropped: assert property (@(posedge sclk) disable iff (sys_rst) // R4
    bit_cnt_r != `ASC_LAST_BIT |=> $stable(word_tgl_r))
    else $error("word taken before 24th edge");

  a_idle_select: assert property (@(posedge sclk) disable iff (sys_rst) // R1
    cs_n |=> $stable(word_r))
    else $error("word changed after select high");

  a_msb_first: assert property (@(posedge sclk) disable iff (cs_n || sys_rst) // R26
    bit_cnt_r == `ASC_LAST_BIT |=>
      word_r == {$past(shift_r), $past(serial_data_in)})
    else $error("word assembled out of order");

  a_soft_self: assert property (@(posedge clk_sys) disable iff (sys_rst) // R10
    soft_rst_r |=> !soft_rst_r && input_swap_bits == `ASC_RST_CH &&
      pattern_mode == ASC_PAT_NONE && !term_enable)
    else $error("soft reset did not restore defaults");

  a_pin_defaults: assert property (@(posedge clk_sys) disable iff (sys_rst) // R9
    !rpin_s2_r |=> channel_sleep_bits == `ASC_RST_CH &&
      !full_sleep_bit && noise_suppress_bits == `ASC_RST_CH)
    else $error("reset pin did not restore defaults");

  a_swap_write: assert property (@(posedge clk_sys) disable iff (sys_rst) // R20
    wr_stb_r && !load_dflt && hit(wr_word_r, `ASC_ADDR_SWAP) |=>
      input_swap_bits == $past(wr_data[7:0]))
    else $error("swap register not written");

  a_ramp_mode: assert property (@(posedge clk_sys) disable iff (sys_rst) // R21
    wr_stb_r && !load_dflt && hit(wr_word_r, `ASC_ADDR_PATTERN) &&
      wr_data[6:4] == 3'h4 |=> pattern_mode == ASC_PAT_RAMP)
    else $error("ramp mode not entered");

  // the full wake outlasts any sane delay range, so its length is counted here
  logic [11:0] wake_age_r;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wake_age_r <= 12'h000;
    end else begin
      wake_age_r <= (power_state == ASC_PWR_WAKE) ? wake_age_r + 12'h001 : 12'h000;
    end
  end
  a_full_wake: assert property (@(posedge clk_sys) disable iff (sys_rst) // R15
    power_state == ASC_PWR_WAKE |-> wake_age_r < {1'b0, FULL_CYC})
    else $error("complete wake too slow");

  a_part_wake: assert property (@(posedge clk_sys) disable iff (sys_rst) // R16
    power_state == ASC_PWR_PART && !full_req && !part_req |->
      ##[1:PART_MAX] (device_awake || full_req || part_req))
    else $error("partial wake too slow");

  a_asleep_flag: assert property (@(posedge clk_sys) disable iff (sys_rst) // R12
    power_state inside {ASC_PWR_PART, ASC_PWR_FULL} |-> !device_awake)
    else $error("awake flag high while asleep");

  c_two_words: cover property (@(posedge sclk) disable iff (cs_n)
    bit_cnt_r == `ASC_LAST_BIT ##24 bit_cnt_r == `ASC_LAST_BIT);
  c_soft_reset: cover property (@(posedge clk_sys) soft_rst_r);
  c_full_wake: cover property (@(posedge clk_sys)
    power_state == ASC_PWR_WAKE ##1 power_state == ASC_PWR_ON);
  c_ramp: cover property (@(posedge clk_sys) pattern_mode == ASC_PAT_RAMP);

endmodule : asc_config_regs
`default_nettype wire

// >>> tb/asc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module asc_host_model (
  // serial link
  output logic sclk,
  output logic cs_n,
  output logic serial_data_in
);
  localparam time HALF = 6ns;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    serial_data_in = 1'b0;
  end
  // ------------------------------------------
  // shifting
  // ------------------------------------------
  // link clock pulses once per shifted bit; idle_pulses also runs it outside frames
  task automatic shift(input logic [23:0] val, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      serial_data_in = val[i];
      #HALF sclk = 1'b1;
      #HALF sclk = 1'b0;
    end
  endtask : shift
  task automatic word(input logic [23:0] val);
    shift(val, 24);
  endtask : word
  task automatic tail(input logic [15:0] val);
    shift({8'h00, val}, 16);
  endtask : tail
  task automatic sel();
    cs_n = 1'b0;
    #10;
  endtask : sel
  // a released data line shows the inverse so a stale bit never looks valid
  task automatic desel();
    #10 cs_n = 1'b1;
    serial_data_in = ~serial_data_in;
  endtask : desel
  // clock and data wiggle while deselected
  task automatic idle_pulses(input int n);
    for (int i = 0; i < n; i++) begin
      serial_data_in = ~serial_data_in;
      #HALF sclk = 1'b1;
      #HALF sclk = 1'b0;
    end
  endtask : idle_pulses
endmodule : asc_host_model
`default_nettype wire

// >>> tb/asc_config_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "asc_map.svh"
module asc_config_regs_tb_top;
  import asc_pkg::*;
  logic clk_sys, sys_rst, sclk, cs_n, serial_data_in, reset_pin_n, sleep_pin;
  logic [7:0] channel_sleep_bits, noise_suppress_bits, input_swap_bits;
  logic partial_sleep_bit, full_sleep_bit, sleep_pin_select_bit, device_awake, term_enable;
  logic [2:0] bitclk_drive_field, frameclk_drive_field, dataout_drive_field;
  logic [2:0] bitclk_term_field, frameclk_term_field, dataout_term_field;
  asc_pwr_t power_state;
  asc_pat_t pattern_mode;
  int fails = 0;
  int checks_done = 0;
  int n;
  logic [2:0] pb [5] = '{3'b100, 3'b010, 3'b001, 3'b000, 3'b011};
  asc_pat_t pe [5] = '{ASC_PAT_RAMP, ASC_PAT_TWO, ASC_PAT_ONE, ASC_PAT_NONE, ASC_PAT_NONE};
  asc_host_model u_asc_host_model (.sclk(sclk), .cs_n(cs_n), .serial_data_in(serial_data_in));
  asc_config_regs u_asc_config_regs (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .sclk(sclk), .cs_n(cs_n),
    .serial_data_in(serial_data_in), .reset_pin_n(reset_pin_n), .sleep_pin(sleep_pin),
    .channel_sleep_bits(channel_sleep_bits), .partial_sleep_bit(partial_sleep_bit),
    .full_sleep_bit(full_sleep_bit), .sleep_pin_select_bit(sleep_pin_select_bit),
    .power_state(power_state), .device_awake(device_awake),
    .bitclk_drive_field(bitclk_drive_field), .frameclk_drive_field(frameclk_drive_field),
    .dataout_drive_field(dataout_drive_field), .term_enable(term_enable),
    .bitclk_term_field(bitclk_term_field), .frameclk_term_field(frameclk_term_field),
    .dataout_term_field(dataout_term_field), .noise_suppress_bits(noise_suppress_bits),
    .input_swap_bits(input_swap_bits), .pattern_mode(pattern_mode)
  );
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // ------------------------------------------
  // helpers
  // ------------------------------------------
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude
  task automatic cycles(input int k);
    repeat (k) @(posedge clk_sys);
  endtask : cycles
  // the register lands a handful of system edges after the last bit
  task automatic wr(input logic [7:0] addr, input logic [15:0] data);
    u_asc_host_model.sel();
    u_asc_host_model.word({addr, data});
    u_asc_host_model.desel();
    cycles(8);
  endtask : wr
  task automatic defaults(input string what);
    chk(what, {bitclk_drive_field, frameclk_drive_field, dataout_drive_field, term_enable},
        16'h0000);
    chk(what, {noise_suppress_bits, input_swap_bits}, 16'h0000);
    chk(what, {channel_sleep_bits, partial_sleep_bit, full_sleep_bit, sleep_pin_select_bit,
               power_state, device_awake}, {11'h000, ASC_PWR_ON, 1'b1});
    chk(what, {bitclk_term_field, frameclk_term_field, dataout_term_field, pattern_mode},
        {9'h000, ASC_PAT_NONE});
  endtask : defaults
  task automatic wake(input int lim);
    n = 0;
    while (device_awake !== 1'b1 && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= lim) begin
      fails++;
      conclude();
    end
  endtask : wake
  task automatic pin(input logic v);
    @(posedge clk_sys);
    sleep_pin <= v;
    cycles(5);
  endtask : pin
  // ------------------------------------------
  // sequence
  // ------------------------------------------
  initial begin
    sys_rst = 1'b1;
    reset_pin_n = 1'b1;
    sleep_pin = 1'b0;
    cycles(2);
    sys_rst <= 1'b0;
    cycles(3);
    defaults("reset");
    $display("test reset done");
    wr(`ASC_ADDR_DRIVE, 16'h0765);
    chk("drive", {dataout_drive_field, frameclk_drive_field, bitclk_drive_field}, 9'h1f5);
    wr(`ASC_ADDR_TERM, 16'h4321);
    chk("term", {term_enable, dataout_term_field, frameclk_term_field, bitclk_term_field},
        10'h2d1);
    $display("test buffers done");
    u_asc_host_model.sel();
    u_asc_host_model.word({`ASC_ADDR_NOISE, 16'h00a5});
    u_asc_host_model.word({`ASC_ADDR_SWAP, 16'h005a});
    u_asc_host_model.tail({`ASC_ADDR_SWAP, 8'hff});
    u_asc_host_model.desel();
    cycles(8);
    chk("noise", noise_suppress_bits, 8'ha5);
    chk("swap", input_swap_bits, 8'h5a);
    u_asc_host_model.idle_pulses(5);
    wr(`ASC_ADDR_NOISE, 16'h0033);
    chk("noise idle", noise_suppress_bits, 8'h33);
    wr(8'h30, 16'hffff);
    chk("unmapped", {noise_suppress_bits, input_swap_bits}, 16'h335a);
    $display("test channels done");
    for (int i = 0; i < 5; i++) begin
      wr(`ASC_ADDR_PATTERN, {9'h000, pb[i], 4'h0});
      chk("pattern", pattern_mode, pe[i]);
    end
    $display("test pattern done");
    wr(`ASC_ADDR_SLEEP, 16'h0100);
    chk("partial", {partial_sleep_bit, power_state, device_awake}, {1'b1, ASC_PWR_PART, 1'b0});
    wr(`ASC_ADDR_SLEEP, 16'h0000);
    wake(200);
    chk("partial wake", n >= 68 && n <= 82, 1'b1);
    wr(`ASC_ADDR_SLEEP, 16'h0200);
    chk("full", {full_sleep_bit, power_state, device_awake}, {1'b1, ASC_PWR_FULL, 1'b0});
    wr(`ASC_ADDR_SLEEP, 16'h0000);
    wake(2200);
    chk("full wake", n >= 1988 && n <= 2002, 1'b1);
    pin(1'b1);
    chk("pin full", power_state, ASC_PWR_FULL);
    pin(1'b0);
    wake(2200);
    wr(`ASC_ADDR_SLEEP, 16'h0400);
    pin(1'b1);
    chk("pin partial", {sleep_pin_select_bit, power_state}, {1'b1, ASC_PWR_PART});
    pin(1'b0);
    wake(200);
    wr(`ASC_ADDR_SLEEP, 16'h00a5);
    chk("channel sleep", {channel_sleep_bits, power_state}, {8'ha5, ASC_PWR_ON});
    $display("test sleep done");
    // reset pin stays high for the register method
    wr(`ASC_ADDR_SOFT_RST, 16'h0001);
    defaults("soft");
    wr(`ASC_ADDR_SWAP, 16'h0081);
    chk("after soft", input_swap_bits, 8'h81);
    @(posedge clk_sys);
    reset_pin_n <= 1'b0;
    cycles(4);
    reset_pin_n <= 1'b1;
    cycles(3);
    defaults("pin reset");
    $display("test resets done");
    conclude();
  end
endmodule : asc_config_regs_tb_top
`default_nettype wire
